// File: core/chpl_pkg.sv
package chpl_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LINK    = 8'h00;
  localparam logic [7:0] OFS_MODE    = 8'h04;
  localparam logic [7:0] OFS_CAPCFG  = 8'h08;
  localparam logic [7:0] OFS_MATCH6  = 8'h0c;
  localparam logic [7:0] OFS_MATCH7  = 8'h10;
  localparam logic [7:0] OFS_ACTIVE  = 8'h14;
  localparam logic [7:0] OFS_CAPTURE = 8'h18;

  // ----------------------------------------------------------------
  // Link control bit positions
  // ----------------------------------------------------------------
  localparam int BIT_RSVD    = 31;
  localparam int BIT_FAULT   = 30;
  localparam int BIT_SYNC    = 29;
  localparam int BIT_DEAD    = 28;
  localparam int BIT_ARM     = 27;
  localparam int BIT_DUAL_EDGE_MODE_ENABLE = 26;
  localparam int BIT_COMP    = 25;
  localparam int BIT_LINK    = 24;

  // ----------------------------------------------------------------
  // Mode and capture configuration fields
  // ----------------------------------------------------------------
  localparam int BIT_WPD      = 2;
  localparam int BIT_MSA      = 0;
  localparam int ELS6_LSB     = 1;
  localparam int ELS7_LSB     = 3;
  localparam int DT_LSB       = 8;
  localparam int DT_W         = 8;
  localparam int MATCH_W      = 16;
  localparam int CNT_W        = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RST_WPD = 1'b0;
  localparam logic [7:0] RST_DT  = 8'h00;

  // ----------------------------------------------------------------
  // Edge select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ELS_OFF  = 2'h0;
  localparam logic [1:0] ELS_RISE = 2'h1;
  localparam logic [1:0] ELS_FALL = 2'h2;
  localparam logic [1:0] ELS_BOTH = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAP_IDLE,
    CAP_FIRST,
    CAP_SECOND
  } chpl_cap_state_t;

endpackage : chpl_pkg

// File: core/chpl_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module chpl_pin_sync
  import chpl_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Pins
  input  wire logic [1:0] pin_in,
  // Synchronised view
  output logic      [1:0] level,
  output logic      [1:0] rise,
  output logic      [1:0] fall
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] last;
  } chpl_sync_state_t;

  chpl_sync_state_t s_r;
  chpl_sync_state_t s_nxt;

  // ----------------------------------------------------------------
  // Two-stage synchroniser and edge history
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = pin_in;
    s_nxt.sync = s_r.meta;
    s_nxt.last = s_r.sync;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.sync;
  assign rise  = s_r.sync & ~s_r.last;
  assign fall  = ~s_r.sync & s_r.last;

endmodule : chpl_pin_sync
`default_nettype wire

// File: core/chpl_pair_ctrl.sv
// Summary of operation
// - Bit 31 reads zero, ignores writes
// - Bit 30 enables fault control on pair
// - Protected bits written only when unprotected
// - Bit 29 syncs match values to trigger
// - Bit 28 inserts deadtime on pair outputs when bit 24 links the pair
// - Bit 27 arms captures on channel 6 input
// - Capture arm works only in dual edge
// - One-shot clears arm after second capture
// - Bit 26 selects dual edge capture mode
// - Bit 25 makes channel 7 inverted copy when bit 24 links the pair
// - Bit 24 links channels 6 and 7
//
// Added by the designer: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module chpl_pair_ctrl
  import chpl_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               rst_b,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Timer side, same clock
  input  wire logic [CNT_W-1:0]   counter_value,
  input  wire logic               sync_trigger,
  input  wire logic               ch6_pwm_in,
  input  wire logic               ch7_pwm_in,
  // Pins
  input  wire logic               ch6_capture_pin,
  input  wire logic               fault_pin,
  output logic                    ch6_out,
  output logic                    ch7_out,
  // Active values to the timer
  output logic      [MATCH_W-1:0] match6_value,
  output logic      [MATCH_W-1:0] match7_value,
  output logic                    fault_active,
  output logic                    capture_active
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  faulten;
    logic                  syncen;
    logic                  dten;
    logic                  arm;
    logic                  dual_edge_mode_enable;
    logic                  comp;
    logic                  linken;
    logic                  wpd;
    logic                  msa;
    logic [1:0]            els6;
    logic [1:0]            els7;
    logic [DT_W-1:0]       dt;
    logic [MATCH_W-1:0]    buf6;
    logic [MATCH_W-1:0]    buf7;
    logic [MATCH_W-1:0]    act6;
    logic [MATCH_W-1:0]    act7;
    logic [CNT_W-1:0]      cap6;
    logic [CNT_W-1:0]      cap7;
    chpl_cap_state_t       cst;
    logic [DT_W-1:0]       dt_cnt;
    logic                  prev_base;
    logic                  o6;
    logic                  o7;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic [31:0]           rdata;
  } chpl_state_t;

  chpl_state_t s_r;
  chpl_state_t s_nxt;

  logic [1:0]  pin_level;
  logic [1:0]  pin_rise;
  logic [1:0]  pin_fall;
  logic        addr_ok;
  logic        fault_hit;
  logic        edge6;
  logic        edge7;
  logic        base;
  logic        tgt6;
  logic        tgt7;
  logic [31:0] link_word;
  logic        cap_run;
  logic        dead_on;
  logic        base_edge;
  logic        wr_link;
  logic        wr_mode;
  logic        wr_capcfg;
  logic        wr_match6;
  logic        wr_match7;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  chpl_pin_sync u_sync (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .pin_in ({fault_pin, ch6_capture_pin}),
    .level  (pin_level),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] els,
                                    input logic       r,
                                    input logic       f);
    logic hit;
    hit = 1'b0;
    unique case (els)
      ELS_OFF:  hit = 1'b0;
      ELS_RISE: hit = r;
      ELS_FALL: hit = f;
      ELS_BOTH: hit = r | f;
    endcase
    return hit;
  endfunction : edge_hit

  function automatic logic [31:0] read_mux(input chpl_state_t s,
                                           input logic [7:0]  a,
                                           input logic [31:0] lw);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      OFS_LINK: begin
        d = lw;
      end
      OFS_MODE: begin
        d[BIT_WPD] = s.wpd;
      end
      OFS_CAPCFG: begin
        d[BIT_MSA]                 = s.msa;
        d[ELS6_LSB +: 2]           = s.els6;
        d[ELS7_LSB +: 2]           = s.els7;
        d[DT_LSB +: DT_W]          = s.dt;
      end
      OFS_MATCH6: begin
        d[MATCH_W-1:0] = s.buf6;
      end
      OFS_MATCH7: begin
        d[MATCH_W-1:0] = s.buf7;
      end
      OFS_ACTIVE: begin
        d = {s.act7, s.act6};
      end
      OFS_CAPTURE: begin
        d = {s.cap7, s.cap6};
      end
      default: begin
        d = 32'h0000_0000;
      end
    endcase
    return d;
  endfunction : read_mux

  // ----------------------------------------------------------------
  // Link control word as software sees it
  // ----------------------------------------------------------------
  always_comb begin
    link_word              = 32'h0000_0000;
    link_word[BIT_RSVD]    = 1'b0;
    link_word[BIT_FAULT]   = s_r.faulten;
    link_word[BIT_SYNC]    = s_r.syncen;
    link_word[BIT_DEAD]    = s_r.dten;
    link_word[BIT_ARM]     = s_r.arm;
    link_word[BIT_DUAL_EDGE_MODE_ENABLE] = s_r.dual_edge_mode_enable;
    link_word[BIT_COMP]    = s_r.comp;
    link_word[BIT_LINK]    = s_r.linken;
  end

  assign addr_ok   = hsel & hready & htrans[1];
  assign fault_hit = s_r.faulten & pin_level[1];
  assign edge6     = edge_hit(s_r.els6, pin_rise[0], pin_fall[0]);
  assign edge7     = edge_hit(s_r.els7, pin_rise[0], pin_fall[0]);
  assign base      = ch6_pwm_in;
  assign tgt6      = s_r.linken ? base : ch6_pwm_in;
  assign tgt7      = s_r.linken ? (s_r.comp ? ~base : base) : ch7_pwm_in;
  assign cap_run   = s_r.dual_edge_mode_enable & s_r.arm;
  assign dead_on   = s_r.linken & s_r.dten;
  assign base_edge = base != s_r.prev_base;

  // ----------------------------------------------------------------
  // Data phase write strobes
  // ----------------------------------------------------------------
  assign wr_link   = s_r.wr_pend & (s_r.wr_addr == OFS_LINK);
  assign wr_mode   = s_r.wr_pend & (s_r.wr_addr == OFS_MODE);
  assign wr_capcfg = s_r.wr_pend & (s_r.wr_addr == OFS_CAPCFG);
  assign wr_match6 = s_r.wr_pend & (s_r.wr_addr == OFS_MATCH6);
  assign wr_match7 = s_r.wr_pend & (s_r.wr_addr == OFS_MATCH7);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Dual edge capture sequencer
    if (!cap_run) begin
      s_nxt.cst = CAP_IDLE;
    end else begin
      unique case (s_r.cst)
        CAP_IDLE: begin
          s_nxt.cst = CAP_FIRST;
        end
        CAP_FIRST: begin
          if (edge6) begin
            s_nxt.cap6 = counter_value;
            s_nxt.cst  = CAP_SECOND;
          end
        end
        CAP_SECOND: begin
          if (edge7) begin
            s_nxt.cap7 = counter_value;
            s_nxt.cst  = CAP_FIRST;
            if (!s_r.msa) begin
              s_nxt.arm = 1'b0;
            end
          end
        end
        default: begin
          s_nxt.cst = CAP_IDLE;
        end
      endcase
    end

    // Match value transfer from buffer to active
    if (!s_r.syncen) begin
      s_nxt.act6 = s_r.buf6;
      s_nxt.act7 = s_r.buf7;
    end else if (sync_trigger) begin
      s_nxt.act6 = s_r.buf6;
      s_nxt.act7 = s_r.buf7;
    end

    // Output path with deadtime and fault forcing
    s_nxt.prev_base = base;
    if (s_r.dual_edge_mode_enable) begin
      s_nxt.o6     = 1'b0;
      s_nxt.o7     = 1'b0;
      s_nxt.dt_cnt = '0;
    end else if (dead_on && base_edge) begin
      s_nxt.dt_cnt = s_r.dt;
      s_nxt.o6     = 1'b0;
      s_nxt.o7     = 1'b0;
    end else if (dead_on && (s_r.dt_cnt != '0)) begin
      s_nxt.dt_cnt = s_r.dt_cnt - 1'b1;
      s_nxt.o6     = 1'b0;
      s_nxt.o7     = 1'b0;
    end else begin
      s_nxt.dt_cnt = '0;
      s_nxt.o6     = tgt6;
      s_nxt.o7     = tgt7;
    end
    if (fault_hit) begin
      s_nxt.o6 = 1'b0;
      s_nxt.o7 = 1'b0;
    end

    // Bus data phase write, after hardware clear so a set wins
    if (wr_link) begin
      s_nxt.syncen = hwdata[BIT_SYNC];
      s_nxt.arm    = hwdata[BIT_ARM];
      if (s_r.wpd) begin
        s_nxt.faulten = hwdata[BIT_FAULT];
        s_nxt.dten    = hwdata[BIT_DEAD];
        s_nxt.dual_edge_mode_enable = hwdata[BIT_DUAL_EDGE_MODE_ENABLE];
        s_nxt.comp    = hwdata[BIT_COMP];
        s_nxt.linken  = hwdata[BIT_LINK];
      end
    end
    if (wr_mode) begin
      s_nxt.wpd = hwdata[BIT_WPD];
    end
    if (wr_capcfg) begin
      s_nxt.msa  = hwdata[BIT_MSA];
      s_nxt.els6 = hwdata[ELS6_LSB +: 2];
      s_nxt.els7 = hwdata[ELS7_LSB +: 2];
      s_nxt.dt   = hwdata[DT_LSB +: DT_W];
    end
    if (wr_match6) begin
      s_nxt.buf6 = hwdata[MATCH_W-1:0];
    end
    if (wr_match7) begin
      s_nxt.buf7 = hwdata[MATCH_W-1:0];
    end

    // Bus address phase
    s_nxt.wr_pend = addr_ok & hwrite;
    s_nxt.wr_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      s_nxt.rdata = read_mux(s_r, haddr[7:0], link_word);
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_r      <= '0;
      s_r.wpd  <= RST_WPD;
      s_r.dt   <= RST_DT;
      s_r.cst  <= CAP_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata         = s_r.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign ch6_out        = s_r.o6;
  assign ch7_out        = s_r.o7;
  assign match6_value   = s_r.act6;
  assign match7_value   = s_r.act7;
  assign fault_active   = fault_hit;
  assign capture_active = cap_run;

endmodule : chpl_pair_ctrl
`default_nettype wire

// File: tb/chpl_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Power stage sense model
// ----
module chpl_pins (
  // Requests from the bench
  input  wire logic fault_req,
  input  wire logic cap_req,
  // Sense lines back to the block
  output logic      fault_pin,
  output logic      ch6_capture_pin
);
  // Slow, unclocked sense paths
  assign #37 fault_pin       = fault_req;
  assign #13 ch6_capture_pin = cap_req;
endmodule : chpl_pins
`default_nettype wire

// File: tb/chpl_pair_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module chpl_monitor
  import chpl_pkg::*;
(
  // Clock and bus
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  // Timer and pins
  input  wire logic        sync_trigger,
  input  wire logic        ch6_out,
  input  wire logic        ch7_out,
  input  wire logic [15:0] match6_value,
  input  wire logic        fault_active,
  input  wire logic        capture_active
);
  // ----
  // Shadow of link bits
  // ----
  logic       wr_r;
  logic       rd_r;
  logic       wpd_r;
  logic [7:0] adr_r;
  logic [7:0] lnk_r;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      wpd_r <= 1'b0;
      adr_r <= 8'h00;
      lnk_r <= 8'h00;
    end else begin
      wr_r  <= hsel && hready && htrans[1] && hwrite;
      rd_r  <= hsel && hready && htrans[1] && !hwrite;
      adr_r <= haddr[7:0];
      if (wr_r && adr_r == OFS_MODE)
        wpd_r <= hwdata[BIT_WPD];
      if (wr_r && adr_r == OFS_LINK)
        lnk_r <= wpd_r ? {1'b0, hwdata[30:24]}
                       : {2'b00, hwdata[29], lnk_r[4], hwdata[27], lnk_r[2:0]} | {1'b0, lnk_r[6], 6'h00};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_pair(logic c);
    lnk_r[0] && lnk_r[1] == c && !lnk_r[4] && !lnk_r[2] && !fault_active;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rsvd_zero: assert property (rd_r && adr_r == OFS_LINK |-> !hrdata[31])
    else $error("reserved bit reads one");
  a_link_readback: assert property (rd_r && adr_r == OFS_LINK |-> (hrdata[31:24] & 8'hf7) == (lnk_r & 8'hf7))
    else $error("link bits read back wrong");
  a_fault_gate: assert property (fault_active |-> lnk_r[6])
    else $error("fault active while disabled");
  a_fault_force: assert property (fault_active |=> !ch6_out && !ch7_out)
    else $error("outputs on during fault");
  a_capture_gate: assert property (capture_active |-> lnk_r[2])
    else $error("capture active outside dual edge");
  a_comp_inverse: assert property (s_pair(1'b1) ##1 s_pair(1'b1) |-> ch7_out != ch6_out)
    else $error("channel 7 not inverse");
  a_comp_copy: assert property (s_pair(1'b0) ##1 s_pair(1'b0) |-> ch7_out == ch6_out)
    else $error("channel 7 not copy");
  a_sync_hold: assert property (lnk_r[5] && !sync_trigger |=> $stable(match6_value))
    else $error("match moved without trigger");
  a_dual_edge_capture_arm_quiet: assert property (lnk_r[2] |=> !ch6_out && !ch7_out)
    else $error("outputs on in dual edge mode");
endmodule : chpl_monitor
bind chpl_pair_ctrl chpl_monitor i_mon (.*);
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import chpl_pkg::*;
  // ----
  // Signals
  // ----
  logic mclk, rst_b, hsel, hwrite, hreadyout, hresp, trg, p6, p7, flt, cap;
  logic fpin, cpin, ch6_out, ch7_out, fault_active, capture_active;
  logic [1:0]  htrans;
  logic [15:0] cnt, m6, m7;
  logic [31:0] haddr, hwdata, hrdata;
  int          n_fail, samples_checked, tmo;
  chpl_pair_ctrl i_dut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .counter_value(cnt),
    .sync_trigger(trg), .ch6_pwm_in(p6), .ch7_pwm_in(p7), .ch6_capture_pin(cpin),
    .fault_pin(fpin), .ch6_out(ch6_out), .ch7_out(ch7_out), .match6_value(m6),
    .match7_value(m7), .fault_active(fault_active), .capture_active(capture_active));
  chpl_pins i_pins (.fault_req(flt), .cap_req(cap), .fault_pin(fpin), .ch6_capture_pin(cpin));
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  function automatic logic [31:0] pins();
    return {29'h0, fault_active, ch7_out, ch6_out};
  endfunction : pins
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    rd(OFS_LINK, 32'h0);
    wr(OFS_LINK, 32'hff000000);
    rd(OFS_LINK, 32'h28000000);
    rd(8'h40, 32'h0);
    wr(OFS_MODE, 32'h4);
    wr(OFS_LINK, 32'hff000000);
    rd(OFS_LINK, 32'h7f000000);
  endtask : t_regs
  task automatic t_pair;
    wr(OFS_LINK, 32'h0);
    p6 <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(pins(), 32'h1);
    wr(OFS_LINK, 32'h01000000);
    repeat (3) @(posedge mclk);
    chk(pins(), 32'h3);
    wr(OFS_LINK, 32'h03000000);
    p6 <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(pins(), 32'h2);
    wr(OFS_CAPCFG, 32'h0300);
    wr(OFS_LINK, 32'h13000000);
    p6 <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(pins(), 32'h0);
    repeat (6) @(posedge mclk);
    chk(pins(), 32'h1);
  endtask : t_pair
  task automatic t_fault;
    wr(OFS_LINK, 32'h41000000);
    flt <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(pins(), 32'h4);
    flt <= 1'b0;
    repeat (6) @(posedge mclk);
    chk(pins(), 32'h3);
    wr(OFS_LINK, 32'h01000000);
    flt <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(pins(), 32'h3);
    flt <= 1'b0;
  endtask : t_fault
  task automatic t_sync;
    wr(OFS_MATCH6, 32'h1234);
    wr(OFS_MATCH7, 32'h9abc);
    repeat (2) @(posedge mclk);
    chk({16'h0, m6}, 32'h1234);
    chk({16'h0, m7}, 32'h9abc);
    wr(OFS_LINK, 32'h20000000);
    wr(OFS_MATCH6, 32'h5678);
    wr(OFS_MATCH7, 32'hdef0);
    repeat (2) @(posedge mclk);
    chk({16'h0, m6}, 32'h1234);
    chk({16'h0, m7}, 32'h9abc);
    trg <= 1'b1;
    @(posedge mclk);
    trg <= 1'b0;
    repeat (2) @(posedge mclk);
    chk({16'h0, m6}, 32'h5678);
    chk({16'h0, m7}, 32'hdef0);
    rd(OFS_ACTIVE, 32'hdef05678);
  endtask : t_sync
  task automatic t_cap;
    logic [31:0] q;
    wr(OFS_LINK, 32'h08000000);
    @(posedge mclk);
    chk({31'h0, capture_active}, 32'h0);
    wr(OFS_CAPCFG, 32'h12);
    wr(OFS_LINK, 32'h0c000000);
    repeat (2) @(posedge mclk);
    chk({31'h0, capture_active}, 32'h1);
    cap <= 1'b1;
    repeat (20) @(posedge mclk);
    cap <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(OFS_LINK, 32'h04000000);
    ahb(1'b0, OFS_CAPTURE, 32'h0, q);
    chk({16'h0, 16'(q[31:16] - q[15:0])}, 32'd20);
  endtask : t_cap
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // ----
  // Clock, timer count, timeout, sequence
  // ----
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cnt <= cnt + 16'h1;
    tmo <= tmo + 1;
    if (tmo == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    {rst_b, hsel, hwrite, trg, p6, p7, flt, cap} = 8'h00;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    cnt = 16'h0;
    tmo = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_pair();
    t_fault();
    t_sync();
    t_cap();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
